//--- rtl/gp8_port.sv
// gp8_port: eight-bit io port with timer capture, clock and compare pins
// assumes: classic wishbone master on clk_i, timer on the same clock,
// pad tristate resolved outside from level and active-low drive enable
`timescale 1ns/100ps

module gp8_port (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [gp8_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [gp8_pkg::DAT_W-1:0] wb_dat_i,
	output logic [gp8_pkg::DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// chip operating mode
	input wire gp8_pkg::gp8_pmode_t pmode_i,
	// timer side
	input wire logic compare_a_out_enable_i,
	input wire logic compare_b_out_enable_i,
	input wire logic timer_compare_out_a_i,
	input wire logic timer_compare_out_b_i,
	output gp8_pkg::gp8_timer_in_t timer_in_o,
	// pads
	input wire logic [gp8_pkg::PORT_W-1:0] pad_i,
	output gp8_pkg::gp8_pad_drv_t pad_drv_o
);

	logic [7:0] port_out_latch;
	logic [7:0] port_direction;
	logic [7:0] pad_level;
	logic [7:0] next_latch;
	logic [7:0] next_direction;
	logic [7:0] next_level;
	logic [7:0] next_drive_n;
	logic [7:0] drv_level;
	logic [7:0] drv_drive_n;
	logic bus_req;
	logic wr_commit;
	logic hold_pins;
	logic float_pins;

	// register decode, shared by the write path and the read path
	function automatic logic hit(input logic [gp8_pkg::ADR_W-1:0] adr, input logic [15:0] idx);
		hit = (adr[gp8_pkg::ADR_W-1:2] == idx) && (adr[1:0] == 2'b00);
	endfunction

	// read-back of the data location, mixing latch and pad per direction bit
	function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] latch,
		input logic [7:0] pads);
		port_view = (dir & latch) | (~dir & pads);
	endfunction

	// pad input synchroniser; the timer inputs read from the filtered copy too
	gp8_sync #(
		.WIDTH(gp8_pkg::PORT_W)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(pad_i),
		.level_o(pad_level)
	);

	// bus handshake: one wait state, write lands on the acked edge
	assign bus_req = wb_cyc_i && wb_stb_i;
	assign wr_commit = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0];

	// ack for one cycle per request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req && !wb_ack_o;
		end
	end

	// read data sampled when the ack is raised; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (bus_req && !wb_ack_o) begin
			wb_dat_o <= '0;
			if (hit(wb_adr_i, gp8_pkg::IDX_OUT_LATCH)) begin
				wb_dat_o[7:0] <= port_view(port_direction, port_out_latch, pad_level);
			end else if (hit(wb_adr_i, gp8_pkg::IDX_DIRECTION)) begin
				wb_dat_o[7:0] <= gp8_pkg::DIR_READ_VALUE;
			end
		end
	end

	// next register values, used by the latch and by the pin registers alike
	always_comb begin
		next_latch = port_out_latch;
		next_direction = port_direction;
		if (wr_commit && hit(wb_adr_i, gp8_pkg::IDX_OUT_LATCH)) begin
			next_latch = wb_dat_i[7:0];
		end
		if (wr_commit && hit(wb_adr_i, gp8_pkg::IDX_DIRECTION)) begin
			next_direction = wb_dat_i[7:0];
		end
	end

	// output latch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_out_latch <= gp8_pkg::RST_OUT_LATCH;
		end else begin
			port_out_latch <= next_latch;
		end
	end

	// direction register, write-only from the bus
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_direction <= gp8_pkg::RST_DIRECTION;
		end else begin
			port_direction <= next_direction;
		end
	end

	// pin function select: compare outputs override the general pin
	always_comb begin
		next_level = next_latch;
		next_drive_n = ~next_direction;
		if (compare_a_out_enable_i) begin
			next_level[gp8_pkg::PIN_CMP_A] = timer_compare_out_a_i;
			next_drive_n[gp8_pkg::PIN_CMP_A] = 1'b0;
		end
		if (compare_b_out_enable_i) begin
			next_level[gp8_pkg::PIN_CMP_B] = timer_compare_out_b_i;
			next_drive_n[gp8_pkg::PIN_CMP_B] = 1'b0;
		end
	end

	// power mode decode
	assign hold_pins = (pmode_i == gp8_pkg::GP8_SLEEP) || (pmode_i == gp8_pkg::GP8_SUBSLEEP)
		|| (pmode_i == gp8_pkg::GP8_WATCH);
	assign float_pins = (pmode_i == gp8_pkg::GP8_STANDBY);

	// pin registers built from next values, so in active and subactive mode a write shows on the pads on the same edge as in the latch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drv_level <= '0;
			drv_drive_n <= gp8_pkg::PADS_FLOAT;
		end else if (hold_pins) begin
			drv_level <= drv_level;
			drv_drive_n <= drv_drive_n;
		end else if (float_pins) begin
			drv_level <= drv_level;
			drv_drive_n <= gp8_pkg::PADS_FLOAT;
		end else begin
			drv_level <= next_level;
			drv_drive_n <= next_drive_n;
		end
	end

	// reset floats the pads at once, not only from the first edge
	always_comb begin
		pad_drv_o.level = drv_level;
		pad_drv_o.drive_n = rst_i ? gp8_pkg::PADS_FLOAT : drv_drive_n;
	end

	// timer inputs taken from the pads in every direction, so an output pin can self-trigger
	always_comb begin
		timer_in_o.cap_d = pad_level[gp8_pkg::PIN_CAP_D];
		timer_in_o.cap_c = pad_level[gp8_pkg::PIN_CAP_C];
		timer_in_o.cap_b = pad_level[gp8_pkg::PIN_CAP_B];
		timer_in_o.cap_a = pad_level[gp8_pkg::PIN_CAP_A];
		timer_in_o.ext_clk = pad_level[gp8_pkg::PIN_EXT_CLK];
	end

	// checks below watch the pads, the bus answer, the latch and direction registers and the timer inputs
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic run_mode;
	assign run_mode = (pmode_i == gp8_pkg::GP8_ACTIVE) || (pmode_i == gp8_pkg::GP8_SUBACTIVE);

	// a fresh read of the data location on the first cycle of a request
	sequence s_read_latch;
		bus_req && !wb_ack_o && !wb_we_i && hit(wb_adr_i, gp8_pkg::IDX_OUT_LATCH);
	endsequence

	// a fresh read of the direction location
	sequence s_read_dir;
		bus_req && !wb_ack_o && !wb_we_i && hit(wb_adr_i, gp8_pkg::IDX_DIRECTION);
	endsequence

	// a write to the data location committed while pins run
	sequence s_write_latch;
		wr_commit && hit(wb_adr_i, gp8_pkg::IDX_OUT_LATCH) && run_mode;
	endsequence

	// pads held still for six sampled cycles; two more than the four the synchroniser needs, which covers a reset release
	sequence s_pads_still;
		$stable(pad_i) [*6];
	endsequence

	// a committed write to the direction location while pins run
	sequence s_write_dir;
		wr_commit && hit(wb_adr_i, gp8_pkg::IDX_DIRECTION) && run_mode;
	endsequence

	AST_DIR_DRIVES: assert property (
		run_mode && $past(run_mode) && !compare_b_out_enable_i && $past(!wr_commit)
		|-> pad_drv_o.drive_n[7:3] == ~port_direction[7:3])
		else $error("pin drive does not follow direction");

	AST_READ_OUTPUTS: assert property (
		s_read_latch |=> wb_ack_o && ((wb_dat_o[7:0] & $past(port_direction)) ==
			($past(port_out_latch) & $past(port_direction))))
		else $error("output pin read-back is not the latch");

	AST_READ_INPUTS: assert property (
		s_read_latch |=> ((wb_dat_o[7:0] & ~$past(port_direction)) ==
			($past(pad_level) & ~$past(port_direction))))
		else $error("input pin read-back is not the pad");

	AST_LATCH_RESET: assert property (
		$past(rst_i) |-> port_out_latch == gp8_pkg::RST_OUT_LATCH)
		else $error("latch not cleared by reset");

	AST_DIR_RESET: assert property (
		$past(rst_i) |-> port_direction == gp8_pkg::RST_DIRECTION && pad_drv_o.drive_n[7:3] == 5'h1f)
		else $error("direction not cleared by reset");

	AST_DIR_READS_ONES: assert property (
		s_read_dir |=> wb_ack_o && wb_dat_o == {24'h000000, gp8_pkg::DIR_READ_VALUE})
		else $error("direction read-back is not all ones");

	AST_CAPTURE_FOLLOWS: assert property (
		s_pads_still |-> timer_in_o.cap_a == pad_i[3] && timer_in_o.cap_d == pad_i[6]
			&& timer_in_o.ext_clk == pad_i[0])
		else $error("timer input does not follow its pad");

	AST_CMP_B_PIN: assert property (
		compare_b_out_enable_i && run_mode |=> run_mode |-> !pad_drv_o.drive_n[2]
			&& pad_drv_o.level[2] == $past(timer_compare_out_b_i))
		else $error("compare b does not own pin 2");

	AST_CMP_A_PIN: assert property (
		compare_a_out_enable_i && run_mode |=> run_mode |-> !pad_drv_o.drive_n[1]
			&& pad_drv_o.level[1] == $past(timer_compare_out_a_i))
		else $error("compare a does not own pin 1");

	AST_STANDBY_FLOAT: assert property (
		pmode_i == gp8_pkg::GP8_STANDBY |=> pad_drv_o.drive_n == gp8_pkg::PADS_FLOAT)
		else $error("pads not floating in standby");

	AST_SLEEP_HOLD: assert property (
		hold_pins |=> $stable(pad_drv_o.level) && $stable(pad_drv_o.drive_n))
		else $error("pads changed in a holding mode");

	AST_WRITE_SHOWS: assert property (
		s_write_latch |=> pad_drv_o.level[7] == $past(wb_dat_i[7]) && pad_drv_o.level[0] == $past(wb_dat_i[0]))
		else $error("latched value not on pins the cycle after the write");

	AST_ACK_ONE: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");

	// a new direction shows on the general pins one edge after it is written
	AST_DIR_WRITE_SHOWS: assert property (
		s_write_dir |=> pad_drv_o.drive_n[7:3] == ~$past(wb_dat_i[7:3]))
		else $error("direction write not on pins the cycle after");

	// output levels of the general pins track the latch on the same edge
	AST_LEVEL_FOLLOWS: assert property (
		run_mode |=> pad_drv_o.level[7:3] == port_out_latch[7:3] && pad_drv_o.level[0] == port_out_latch[0])
		else $error("pin level does not follow the latch");

	// with compare a off, pin 1 is a plain port pin
	AST_PIN1_PLAIN: assert property (
		!compare_a_out_enable_i && run_mode |=> pad_drv_o.drive_n[1] == !port_direction[1]
			&& pad_drv_o.level[1] == port_out_latch[1])
		else $error("pin 1 not a plain pin with compare a off");

	// with compare b off, pin 2 is a plain port pin
	AST_PIN2_PLAIN: assert property (
		!compare_b_out_enable_i && run_mode |=> pad_drv_o.drive_n[2] == !port_direction[2]
			&& pad_drv_o.level[2] == port_out_latch[2])
		else $error("pin 2 not a plain pin with compare b off");

	// standby floats the pads but keeps the last level for the way back
	AST_STANDBY_LEVEL: assert property (
		pmode_i == gp8_pkg::GP8_STANDBY |=> $stable(pad_drv_o.level))
		else $error("pad level changed in standby");

	// reset floats every pad in the same cycle, so the default reset guard is off here
	AST_FLOAT_IN_RESET: assert property (
		disable iff (1'b0) rst_i |-> pad_drv_o.drive_n == gp8_pkg::PADS_FLOAT)
		else $error("pads driven during reset");

	// the latch moves only on a committed write
	AST_LATCH_KEEPS: assert property (
		!wr_commit |=> $stable(port_out_latch))
		else $error("latch changed without a write");

	// the direction register moves only on a committed write
	AST_DIR_KEEPS: assert property (
		!wr_commit |=> $stable(port_direction))
		else $error("direction changed without a write");

	// every request taken is answered on the next edge
	AST_ACK_ANSWER: assert property (
		bus_req && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in one cycle");

	// no answer without a request standing on the edge before
	AST_ACK_HAS_REQ: assert property (
		wb_ack_o |-> $past(bus_req))
		else $error("ack without a request");

	// only the low byte carries data; the rest of the word reads zero
	AST_UPPER_ZERO: assert property (
		wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper read data not zero");

	// the timer inputs start from zero after reset, like the synchroniser
	AST_TIMER_IN_RESET: assert property (
		$past(rst_i) |-> timer_in_o == '0)
		else $error("timer inputs not cleared by reset");

	// capture inputs b and c follow their pads once the pads have settled
	AST_CAPTURE_BC: assert property (
		s_pads_still |-> timer_in_o.cap_b == pad_i[4] && timer_in_o.cap_c == pad_i[5])
		else $error("capture b or c does not follow its pad");

endmodule

//--- rtl/gp8_pkg.sv
// gp8_pkg: constants, carrier types and power modes for the eight-bit io port
// assumes: word-wide classic wishbone slave, register index = byte address / 4
package gp8_pkg;

	// register indexes; byte address is four times the index
	localparam logic [15:0] IDX_OUT_LATCH = 16'hffdb;
	localparam logic [15:0] IDX_DIRECTION = 16'hffeb;
	localparam int ADR_W = 18;
	localparam int DAT_W = 32;
	localparam int PORT_W = 8;

	// reset values and read-back of the write-only register
	localparam logic [7:0] RST_OUT_LATCH = 8'h00;
	localparam logic [7:0] RST_DIRECTION = 8'h00;
	localparam logic [7:0] DIR_READ_VALUE = 8'hff;
	localparam logic [7:0] PADS_FLOAT = 8'hff;

	// pin positions of the timer functions
	localparam int PIN_EXT_CLK = 0;
	localparam int PIN_CMP_A = 1;
	localparam int PIN_CMP_B = 2;
	localparam int PIN_CAP_A = 3;
	localparam int PIN_CAP_B = 4;
	localparam int PIN_CAP_C = 5;
	localparam int PIN_CAP_D = 6;

	// synchroniser depth for pad inputs
	localparam int SYNC_STAGES = 3;

	// chip operating mode as seen by the port
	typedef enum logic [2:0] {
		GP8_ACTIVE,
		GP8_SUBACTIVE,
		GP8_SLEEP,
		GP8_SUBSLEEP,
		GP8_WATCH,
		GP8_STANDBY
	} gp8_pmode_t;

	// pad drive bundle: level and active-low enable
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] drive_n;
	} gp8_pad_drv_t;

	// the four capture inputs and the counter clock for the timer
	typedef struct packed {
		logic cap_d;
		logic cap_c;
		logic cap_b;
		logic cap_a;
		logic ext_clk;
	} gp8_timer_in_t;

endpackage

//--- rtl/gp8_sync.sv
// gp8_sync: three-flop pad synchroniser with agreement filter
// assumes: pad levels are asynchronous to clk_i
`timescale 1ns/100ps
module gp8_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// asynchronous pads in, filtered levels out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] level_o
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// shift chain; stage1 feeds only stage2 to keep metastability contained
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= async_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a bit changes only once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_o <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					level_o[i] <= stage2[i];
				end
			end
		end
	end

endmodule

//--- sim/gp8_pad_model.sv
// gp8_pad_model: board pads and the compare side of the free-running timer
// assumes: one clock shared with the port, bench sets the far-side levels
`timescale 1ns/100ps
module gp8_pad_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// port side
	input wire gp8_pkg::gp8_pad_drv_t pad_drv_i,
	output logic [7:0] pad_o,
	// bench side
	input wire logic [7:0] ext_level_i,
	input wire logic [1:0] cmp_set_i,
	input wire logic [1:0] en_set_i,
	// timer compare outputs and enables, {b,a}
	output logic [1:0] cmp_o,
	output logic [1:0] en_o
);
	// a driven pin wins over the external driver, which is weak
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pad_o[i] = (pad_drv_i.drive_n[i] === 1'b0) ? pad_drv_i.level[i] : ext_level_i[i];
		end
	end
	// the timer registers its compare levels and enables on the shared clock
	always_ff @(posedge clk_i) begin
		cmp_o <= rst_i ? 2'h0 : cmp_set_i;
		en_o <= rst_i ? 2'h0 : en_set_i;
	end
endmodule

//--- sim/test_gp8_port.sv
// test_gp8_port: register tests of the io port through wishbone calls
// assumes: pad model on the far side, timer compare levels from that model
`timescale 1ns/100ps
module test_gp8_port;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [17:0] adr = 0;
	logic [31:0] wd = 0, wb_dat_o;
	logic wb_ack_o;
	logic [7:0] ext = 8'h5a, pad;
	logic [1:0] cmp_set = 0, en_set = 0, cmp, en;
	gp8_pkg::gp8_pmode_t pmode = gp8_pkg::GP8_ACTIVE;
	gp8_pkg::gp8_timer_in_t tin;
	gp8_pkg::gp8_pad_drv_t drv;
	int n_errors = 0, compares = 0, cycles = 0;
	localparam logic [17:0] A_LAT = 18'h3ff6c, A_DIR = 18'h3ffac, A_NONE = 18'h3ff70;

	gp8_port gp8_port_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wd), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.pmode_i(pmode), .compare_a_out_enable_i(en[0]), .compare_b_out_enable_i(en[1]),
		.timer_compare_out_a_i(cmp[0]), .timer_compare_out_b_i(cmp[1]), .timer_in_o(tin),
		.pad_i(pad), .pad_drv_o(drv));
	gp8_pad_model gp8_pad_model_i (.clk_i(clk_i), .rst_i(rst_i), .pad_drv_i(drv), .pad_o(pad),
		.ext_level_i(ext), .cmp_set_i(cmp_set), .en_set_i(en_set), .cmp_o(cmp), .en_o(en));

	// 20 MHz clock
	always #25 clk_i = ~clk_i;

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic summarize();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(int n);
		repeat (n) @(posedge clk_i);
	endtask

	// one classic cycle; the request holds until ack is sampled high
	task automatic bus(logic w, logic [17:0] a, logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask

	task automatic wr(logic [17:0] a, logic [7:0] d);
		logic [31:0] r;
		bus(1, a, {24'h0, d}, r);
	endtask

	task automatic rd(string name, logic [17:0] a, logic [31:0] exp);
		logic [31:0] r;
		bus(0, a, 0, r);
		chk(name, r, exp);
	endtask

	// modes in which the pins keep their last state
	gp8_pkg::gp8_pmode_t hold_modes[3] = '{gp8_pkg::GP8_SLEEP, gp8_pkg::GP8_SUBSLEEP, gp8_pkg::GP8_WATCH};

	initial begin
		tick(10);
		chk("drive_n in reset", {24'h0, drv.drive_n}, 32'hff);
		tick(6);
		rst_i <= 0;
		tick(1);
		chk("drive_n after reset", {24'h0, drv.drive_n}, 32'hff);
		chk("level after reset", {24'h0, drv.level}, 32'h0);
		tick(4); // pads need four edges through the synchroniser after reset
		rd("read pads", A_LAT, 32'h5a);
		rd("read dir", A_DIR, 32'hff);
		rd("unmapped", A_NONE, 32'h0);
		// mixed direction: upper nibble from latch, lower from pads
		wr(A_DIR, 8'hf0);
		wr(A_LAT, 8'ha5);
		ext <= 8'h3c;
		tick(1);
		chk("drive_n mixed", {24'h0, drv.drive_n}, 32'h0f);
		chk("level written", {24'h0, drv.level}, 32'ha5);
		tick(6);
		rd("read mixed", A_LAT, 32'hac);
		rd("read dir set", A_DIR, 32'hff);
		// timer inputs follow the pins as outputs and as inputs
		wr(A_DIR, 8'hff);
		wr(A_LAT, 8'h59);
		tick(7);
		chk("timer in out", {27'h0, tin}, 32'h17);
		wr(A_DIR, 8'h00);
		ext <= 8'h26;
		tick(7);
		chk("timer in in", {27'h0, tin}, 32'h08);
		// compare outputs take pins 1 and 2 while their enables are set
		en_set <= 2'b11;
		cmp_set <= 2'b01;
		tick(4);
		chk("cmp drive", {30'h0, drv.drive_n[2:1]}, 32'h0);
		chk("cmp level 01", {30'h0, drv.level[2:1]}, 32'h1);
		cmp_set <= 2'b10;
		tick(4);
		chk("cmp level 10", {30'h0, drv.level[2:1]}, 32'h2);
		en_set <= 2'b00;
		tick(4);
		chk("cmp released", {30'h0, drv.drive_n[2:1]}, 32'h3);
		// holding modes freeze the pins even though the latch is written
		wr(A_DIR, 8'hff);
		wr(A_LAT, 8'h00);
		foreach (hold_modes[k]) begin
			pmode <= hold_modes[k];
			wr(A_LAT, 8'hff);
			tick(2);
			chk("held level", {24'h0, drv.level}, 32'h0);
			chk("held drive", {24'h0, drv.drive_n}, 32'h0);
			pmode <= gp8_pkg::GP8_ACTIVE;
			wr(A_LAT, 8'h00);
		end
		pmode <= gp8_pkg::GP8_STANDBY;
		tick(2);
		chk("standby float", {24'h0, drv.drive_n}, 32'hff);
		pmode <= gp8_pkg::GP8_SUBACTIVE;
		wr(A_LAT, 8'h81);
		tick(2);
		chk("subactive level", {24'h0, drv.level}, 32'h81);
		chk("subactive drive", {24'h0, drv.drive_n}, 32'h0);
		// a reset in mid-run clears a written latch and direction
		rst_i <= 1;
		tick(2);
		chk("drive_n in reset 2", {24'h0, drv.drive_n}, 32'hff);
		rst_i <= 0;
		tick(1);
		chk("drive_n after reset 2", {24'h0, drv.drive_n}, 32'hff);
		chk("level after reset 2", {24'h0, drv.level}, 32'h0);
		wr(A_DIR, 8'hff);
		rd("latch after reset 2", A_LAT, 32'h0);
		summarize();
	end
endmodule
